// *** core/cms_regs.sv ***
`timescale 1ns/1ps
// What this block does
// - converter active bits: 0 standby, 1 active
// - converter sleep bits: 1 selects LDO in sleep
// - state machine reset restores mode and action fields
// - low supply: interrupt, plus shutdown if action set
// - hibernate bit keeps comparator running in hibernate
// - turn-off threshold bits 6:4, default 010
// - turn-on threshold bits 2:0, default 101
// - thresholds writable only with key unlocked
module cms_regs (
  input  wire logic                          i_mclk,                // 250 MHz block clock
  input  wire logic                          i_srst,                // synchronous reset, active high
  input  wire logic [cms_pkg::CMS_AW-1:0]    i_addr,                // register index
  input  wire logic [cms_pkg::CMS_DW-1:0]    i_wdata,               // write data
  input  wire logic                          i_wr,                  // write strobe
  input  wire logic                          i_rd,                  // read strobe
  output logic      [cms_pkg::CMS_DW-1:0]    o_rdata,               // read data, cycle after i_rd
  input  wire logic                          i_sm_reset,            // power state machine reset pulse
  input  wire logic                          i_key_unlocked,        // security key state
  input  wire logic                          i_hibernate,           // power state is hibernate
  input  wire logic                          i_supply_low,          // comparator: below turn-off level
  output logic                               o_conv1_active_sel,    // converter 1 active mode
  output logic                               o_conv3_active_sel,    // converter 3 active mode
  output logic                               o_conv1_sleep_ldo,     // converter 1 LDO in sleep
  output logic                               o_conv3_sleep_ldo,     // converter 3 LDO in sleep
  output logic                               o_conv4_sleep_ldo,     // converter 4 LDO in sleep
  output logic                               o_conv6_sleep_ldo,     // converter 6 LDO in sleep
  output logic      [cms_pkg::CMS_THR_W-1:0] o_turn_off_threshold,  // critical level code
  output logic      [cms_pkg::CMS_THR_W-1:0] o_turn_on_threshold,   // turn-on level code
  output logic                               o_comp_enable,         // comparator powered
  output logic                               o_hard_shutdown,       // one cycle shutdown request
  output logic                               o_irq                  // level interrupt
);
  import cms_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic                 conv1_act;   // conv1_active_sel
    logic                 conv3_act;   // conv3_active_sel
    logic                 conv1_slp;   // conv1_sleep_ldo
    logic                 conv3_slp;   // conv3_sleep_ldo
    logic                 conv4_slp;   // conv4_sleep_ldo
    logic                 conv6_slp;   // conv6_sleep_ldo
    logic                 action;      // low_supply_action
    logic                 hib_use;     // comparator_hibernate_use
    logic [CMS_THR_W-1:0] off_thr;     // turn_off_threshold
    logic [CMS_THR_W-1:0] on_thr;      // turn_on_threshold
    logic [CMS_IRQ_W-1:0] mask;        // interrupt enables
    logic                 low_prev;    // last synchronised supply level
    logic                 comp_en;     // comparator enable output
    logic                 shutdown;    // shutdown pulse output
    logic [CMS_DW-1:0]    rdata;       // read data output
  } cms_state_t;

  cms_state_t           st_q;       // registered state
  cms_state_t           st_d;       // next state
  logic                 low_sync;   // synchronised comparator level
  logic                 crit_evt;   // supply just fell below turn-off
  logic                 lock_evt;   // threshold write refused
  logic                 stat_clr;   // status register read
  logic [CMS_IRQ_W-1:0] evt;        // event vector
  logic [CMS_IRQ_W-1:0] flags;      // sticky status
  logic                 wr_act;     // write to active register
  logic                 wr_slp;     // write to sleep register
  logic                 wr_sup;     // write to supply register

  // ************************************************************
  // comparator input crossing
  // ************************************************************
  // the comparator is analog, so its level is asynchronous
  cms_sync2 u_low_sync (
    .i_mclk  (i_mclk),
    .i_srst  (i_srst),
    .i_async (i_supply_low),
    .o_sync  (low_sync)
  );

  // ************************************************************
  // decode and events
  // ************************************************************
  assign wr_act   = i_wr && (i_addr == CMS_ADDR_ACTIVE);
  assign wr_slp   = i_wr && (i_addr == CMS_ADDR_SLEEP);
  assign wr_sup   = i_wr && (i_addr == CMS_ADDR_SUPPLY);
  assign stat_clr = i_rd && (i_addr == CMS_ADDR_IRQ_STAT);

  // only a falling supply seen while the comparator runs counts
  assign crit_evt = low_sync && !st_q.low_prev && st_q.comp_en;
  // any write to the supply register while locked is flagged
  assign lock_evt = wr_sup && !i_key_unlocked;

  always_comb begin
    evt                   = '0;
    evt[CMS_IRQ_CRIT_BIT] = crit_evt;
    evt[CMS_IRQ_LOCK_BIT] = lock_evt;
  end

  // ************************************************************
  // sticky status bits, cleared by reading them
  // ************************************************************
  for (genvar g = 0; g < CMS_IRQ_W; g++) begin : g_flag
    cms_sticky u_flag (
      .i_mclk (i_mclk),
      .i_srst (i_srst),
      .i_set  (evt[g]),
      .i_clr  (stat_clr),
      .o_flag (flags[g])
    );
  end

  // level interrupt while any enabled flag is held
  assign o_irq = |(flags & st_q.mask);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_d          = st_q;
    st_d.rdata    = '0;
    st_d.shutdown = 1'b0;
    st_d.low_prev = low_sync;

    // comparator runs outside hibernate, or inside it on request
    st_d.comp_en = !i_hibernate || st_q.hib_use;

    // shutdown only when the action bit asks for it
    if (crit_evt && st_q.action) begin
      st_d.shutdown = 1'b1;
    end

    // active register: only bits 2 and 0 live here
    if (wr_act) begin
      st_d.conv3_act = i_wdata[CMS_ACT_CONV3_BIT];
      st_d.conv1_act = i_wdata[CMS_ACT_CONV1_BIT];
    end

    // sleep register: four LDO selects
    if (wr_slp) begin
      st_d.conv6_slp = i_wdata[CMS_SLP_CONV6_BIT];
      st_d.conv4_slp = i_wdata[CMS_SLP_CONV4_BIT];
      st_d.conv3_slp = i_wdata[CMS_SLP_CONV3_BIT];
      st_d.conv1_slp = i_wdata[CMS_SLP_CONV1_BIT];
    end

    // supply register: action and hibernate bits are always open
    if (wr_sup) begin
      st_d.action  = i_wdata[CMS_SUP_ACTION_BIT];
      st_d.hib_use = i_wdata[CMS_SUP_HIB_BIT];
      // codes step 0.1 V from 2.9 V; a locked write leaves them alone
      if (i_key_unlocked) begin
        st_d.off_thr = i_wdata[CMS_SUP_OFF_LSB +: CMS_THR_W];
        st_d.on_thr  = i_wdata[CMS_SUP_ON_LSB +: CMS_THR_W];
      end
    end

    // interrupt mask
    if (i_wr && (i_addr == CMS_ADDR_IRQ_MASK)) begin
      st_d.mask = i_wdata[CMS_IRQ_W-1:0];
    end

    // state machine reset beats a write in the same cycle
    if (i_sm_reset) begin
      st_d.conv1_act = CMS_ACT_RST;
      st_d.conv3_act = CMS_ACT_RST;
      st_d.conv1_slp = CMS_SLP_RST;
      st_d.conv3_slp = CMS_SLP_RST;
      st_d.conv4_slp = CMS_SLP_RST;
      st_d.conv6_slp = CMS_SLP_RST;
      st_d.action    = CMS_ACTION_RST;
    end

    // read data, valid only in the cycle after the strobe
    if (i_rd) begin
      case (i_addr)
        CMS_ADDR_ACTIVE: begin
          st_d.rdata[CMS_ACT_CONV3_BIT] = st_q.conv3_act;
          st_d.rdata[CMS_ACT_CONV1_BIT] = st_q.conv1_act;
        end
        CMS_ADDR_SLEEP: begin
          st_d.rdata[CMS_SLP_CONV6_BIT] = st_q.conv6_slp;
          st_d.rdata[CMS_SLP_CONV4_BIT] = st_q.conv4_slp;
          st_d.rdata[CMS_SLP_CONV3_BIT] = st_q.conv3_slp;
          st_d.rdata[CMS_SLP_CONV1_BIT] = st_q.conv1_slp;
        end
        CMS_ADDR_SUPPLY: begin
          st_d.rdata[CMS_SUP_ACTION_BIT]             = st_q.action;
          st_d.rdata[CMS_SUP_HIB_BIT]                = st_q.hib_use;
          st_d.rdata[CMS_SUP_OFF_LSB +: CMS_THR_W]   = st_q.off_thr;
          st_d.rdata[CMS_SUP_ON_LSB +: CMS_THR_W]    = st_q.on_thr;
        end
        CMS_ADDR_IRQ_STAT: begin
          st_d.rdata[CMS_IRQ_W-1:0] = flags;
        end
        CMS_ADDR_IRQ_MASK: begin
          st_d.rdata[CMS_IRQ_W-1:0] = st_q.mask;
        end
        default: begin
          st_d.rdata = '0;  // unmapped reads as zero
        end
      endcase
    end

    // bank reset: every field to its default
    if (i_srst) begin
      st_d           = '0;
      st_d.conv1_act = CMS_ACT_RST;
      st_d.conv3_act = CMS_ACT_RST;
      st_d.conv1_slp = CMS_SLP_RST;
      st_d.conv3_slp = CMS_SLP_RST;
      st_d.conv4_slp = CMS_SLP_RST;
      st_d.conv6_slp = CMS_SLP_RST;
      st_d.action    = CMS_ACTION_RST;
      st_d.hib_use   = CMS_HIB_RST;
      st_d.off_thr   = CMS_OFF_THR_RST;
      st_d.on_thr    = CMS_ON_THR_RST;
      st_d.mask      = CMS_MASK_RST;
      st_d.comp_en   = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge i_mclk) begin
    st_q <= st_d;
  end

  // ************************************************************
  // outputs, all from flops except the interrupt
  // ************************************************************
  assign o_rdata              = st_q.rdata;
  assign o_conv1_active_sel   = st_q.conv1_act;
  assign o_conv3_active_sel   = st_q.conv3_act;
  assign o_conv1_sleep_ldo    = st_q.conv1_slp;
  assign o_conv3_sleep_ldo    = st_q.conv3_slp;
  assign o_conv4_sleep_ldo    = st_q.conv4_slp;
  assign o_conv6_sleep_ldo    = st_q.conv6_slp;
  assign o_turn_off_threshold = st_q.off_thr;
  assign o_turn_on_threshold  = st_q.on_thr;
  assign o_comp_enable        = st_q.comp_en;
  assign o_hard_shutdown      = st_q.shutdown;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  sm_act_default_a: assert property (i_sm_reset |=> o_conv1_active_sel && o_conv3_active_sel)
    else $error("active bits not restored by state machine reset");

  act_write_a: assert property (wr_act && !i_sm_reset |=>
      o_conv3_active_sel == $past(i_wdata[2]) && o_conv1_active_sel == $past(i_wdata[0]))
    else $error("active bit write not taken");

  slp_write_a: assert property (wr_slp && !i_sm_reset |=>
      {o_conv6_sleep_ldo, o_conv4_sleep_ldo, o_conv3_sleep_ldo, o_conv1_sleep_ldo}
      == {$past(i_wdata[5]), $past(i_wdata[3]), $past(i_wdata[2]), $past(i_wdata[0])})
    else $error("sleep bit write not taken");

  sm_sleep_clear_a: assert property (i_sm_reset |=>
      !(o_conv6_sleep_ldo || o_conv4_sleep_ldo || o_conv3_sleep_ldo || o_conv1_sleep_ldo) && !st_q.action)
    else $error("sleep or action not restored by state machine reset");

  shutdown_on_a: assert property (crit_evt && st_q.action |=> o_hard_shutdown ##1 !o_hard_shutdown)
    else $error("hard shutdown missing or too long");

  shutdown_off_a: assert property (o_hard_shutdown |-> flags[CMS_IRQ_CRIT_BIT] && $past(st_q.action))
    else $error("shutdown without interrupt or action");

  hib_comp_a: assert property (i_hibernate && !st_q.hib_use |=> !o_comp_enable)
    else $error("comparator left on in hibernate");

  thr_locked_a: assert property (wr_sup && !i_key_unlocked && !i_srst |=>
      $stable(o_turn_off_threshold) && $stable(o_turn_on_threshold))
    else $error("threshold changed while locked");

  thr_open_a: assert property (wr_sup && i_key_unlocked |=>
      o_turn_off_threshold == $past(i_wdata[6:4]) && o_turn_on_threshold == $past(i_wdata[2:0]))
    else $error("threshold write not taken");

  lock_flag_a: assert property (lock_evt |=> flags[CMS_IRQ_LOCK_BIT] [*2] or (flags[CMS_IRQ_LOCK_BIT] ##1 1'b1))
    else $error("locked write not flagged");

  rdata_idle_a: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside read slot");

  crit_flag_a: assert property (crit_evt |=> flags[CMS_IRQ_CRIT_BIT])
    else $error("critical supply event not flagged");

  no_stop_a: assert property (!(crit_evt && st_q.action) |=> !o_hard_shutdown)
    else $error("hard shutdown without action bit");

  comp_on_a: assert property (!i_hibernate || st_q.hib_use |=> o_comp_enable)
    else $error("comparator off while it should run");

  sm_keep_thr_a: assert property (i_sm_reset && !wr_sup |=>
      $stable(o_turn_off_threshold) && $stable(o_turn_on_threshold))
    else $error("state machine reset touched thresholds");

  crit_cov_c: cover property (crit_evt && st_q.action ##1 o_hard_shutdown);
  lock_cov_c: cover property (lock_evt ##1 o_irq);
  smr_cov_c:  cover property (i_sm_reset && wr_act);
  clr_cov_c:  cover property (stat_clr && |evt);

endmodule

// *** core/cms_pkg.sv ***
// ************************************************************
// converter mode and supply check constants
// ************************************************************
package cms_pkg;

  // ************************************************************
  // bus geometry
  // ************************************************************
  localparam int CMS_AW = 8;   // register index width
  localparam int CMS_DW = 16;  // register data width

  // ************************************************************
  // register offsets (plain port, printed offsets used directly)
  // ************************************************************
  localparam logic [7:0] CMS_ADDR_ACTIVE   = 8'hb1;  // converter_active_select
  localparam logic [7:0] CMS_ADDR_SLEEP    = 8'hb2;  // converter_sleep_select
  localparam logic [7:0] CMS_ADDR_SUPPLY   = 8'hb3;  // supply_check_comparator
  localparam logic [7:0] CMS_ADDR_IRQ_STAT = 8'hc0;  // sticky event status
  localparam logic [7:0] CMS_ADDR_IRQ_MASK = 8'hc1;  // interrupt enables

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CMS_ACT_CONV3_BIT  = 2;   // conv3_active_sel
  localparam int CMS_ACT_CONV1_BIT  = 0;   // conv1_active_sel
  localparam int CMS_SLP_CONV6_BIT  = 5;   // conv6_sleep_ldo
  localparam int CMS_SLP_CONV4_BIT  = 4 - 1;  // conv4_sleep_ldo, bit 3
  localparam int CMS_SLP_CONV3_BIT  = 2;   // conv3_sleep_ldo
  localparam int CMS_SLP_CONV1_BIT  = 0;   // conv1_sleep_ldo
  localparam int CMS_SUP_ACTION_BIT = 14;  // low_supply_action
  localparam int CMS_SUP_HIB_BIT    = 12;  // comparator_hibernate_use
  localparam int CMS_SUP_OFF_LSB    = 4;   // turn_off_threshold, bits 6:4
  localparam int CMS_SUP_ON_LSB     = 0;   // turn_on_threshold, bits 2:0
  localparam int CMS_THR_W          = 3;   // threshold code width
  localparam int CMS_IRQ_W          = 2;   // number of event bits
  localparam int CMS_IRQ_CRIT_BIT   = 0;   // critical supply event
  localparam int CMS_IRQ_LOCK_BIT   = 1;   // locked threshold write event

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic                 CMS_ACT_RST     = 1'b1;  // active mode
  localparam logic                 CMS_SLP_RST     = 1'b0;  // normal switching
  localparam logic                 CMS_ACTION_RST  = 1'b0;  // interrupt only
  localparam logic                 CMS_HIB_RST     = 1'b0;  // comparator unused
  localparam logic [CMS_THR_W-1:0] CMS_OFF_THR_RST = 3'h2;  // 3.1 V
  localparam logic [CMS_THR_W-1:0] CMS_ON_THR_RST  = 3'h5;  // 3.4 V
  localparam logic [CMS_IRQ_W-1:0] CMS_MASK_RST    = 2'h0;  // all masked

endpackage

// *** core/cms_sync2.sv ***
`timescale 1ns/1ps
// ************************************************************
// two flop level synchroniser
// ************************************************************
module cms_sync2 (
  input  wire logic i_mclk,   // block clock
  input  wire logic i_srst,   // synchronous reset, active high
  input  wire logic i_async,  // level from outside the clock domain
  output logic      o_sync    // level safe to use
);
  import cms_pkg::*;

  // first stage is only read by the second stage
  typedef struct packed {
    logic meta;  // first stage, may go metastable
    logic sync;  // second stage, safe
  } cms_sync_t;

  cms_sync_t st_q;  // registered state
  cms_sync_t st_d;  // next state

  // next state: shift the level along the chain
  always_comb begin
    st_d      = st_q;
    st_d.meta = i_async;
    st_d.sync = st_q.meta;
    if (i_srst) begin
      st_d = '0;
    end
  end

  // single state register
  always_ff @(posedge i_mclk) begin
    st_q <= st_d;
  end

  assign o_sync = st_q.sync;

endmodule

// *** core/cms_sticky.sv ***
`timescale 1ns/1ps
// ************************************************************
// sticky event flag, set beats clear
// ************************************************************
module cms_sticky (
  input  wire logic i_mclk,  // block clock
  input  wire logic i_srst,  // synchronous reset, active high
  input  wire logic i_set,   // event pulse
  input  wire logic i_clr,   // clear pulse (status read)
  output logic      o_flag   // sticky flag
);
  import cms_pkg::*;

  typedef struct packed {
    logic flag;  // held event
  } cms_flag_t;

  cms_flag_t st_q;  // registered state
  cms_flag_t st_d;  // next state

  // a set in the clearing cycle survives, so no event is lost
  always_comb begin
    st_d = st_q;
    if (i_set) begin
      st_d.flag = 1'b1;
    end else if (i_clr) begin
      st_d.flag = 1'b0;
    end
    if (i_srst) begin
      st_d = '0;
    end
  end

  // single state register
  always_ff @(posedge i_mclk) begin
    st_q <= st_d;
  end

  assign o_flag = st_q.flag;

endmodule

// *** tb/cms_regs_tb.sv ***
`timescale 1ns/1ps
// ************************************************************
// self-checking bench for the converter mode register bank
// ************************************************************
module cms_regs_tb;
  import cms_pkg::*;
  logic              i_mclk;          // 250 MHz block clock
  logic              i_srst;          // synchronous reset
  logic [CMS_AW-1:0] i_addr;          // register index
  logic [CMS_DW-1:0] i_wdata;         // write data
  logic              i_wr;            // write strobe
  logic              i_rd;            // read strobe
  logic [CMS_DW-1:0] o_rdata;         // read data
  logic              i_sm_reset;      // power state machine reset
  logic              i_key_unlocked;  // key state
  logic              i_hibernate;     // hibernate state
  logic              i_supply_low;    // raw comparator level
  logic              o_c1a, o_c3a;    // active selects
  logic [3:0]        o_slp;           // sleep bits {6,4,3,1} in 3:0
  logic [2:0]        o_off, o_on;     // threshold codes
  logic              o_comp_enable;   // comparator powered
  logic              o_hard_shutdown; // shutdown pulse
  logic              o_irq;           // level interrupt
  int                fails;           // mismatches seen
  int                total_checks;    // comparisons made
  logic [CMS_DW-1:0] d;               // last read word

  cms_regs cms_regs_inst (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sm_reset(i_sm_reset),
    .i_key_unlocked(i_key_unlocked), .i_hibernate(i_hibernate), .i_supply_low(i_supply_low),
    .o_conv1_active_sel(o_c1a), .o_conv3_active_sel(o_c3a), .o_conv1_sleep_ldo(o_slp[0]),
    .o_conv3_sleep_ldo(o_slp[1]), .o_conv4_sleep_ldo(o_slp[2]), .o_conv6_sleep_ldo(o_slp[3]),
    .o_turn_off_threshold(o_off), .o_turn_on_threshold(o_on), .o_comp_enable(o_comp_enable),
    .o_hard_shutdown(o_hard_shutdown), .o_irq(o_irq));

  // ************************************************************
  // shared bus and compare tasks
  // ************************************************************
  // one word compare, counts and reports
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write, ends settled after the next edge
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1;
  endtask
  // one-cycle read, data sampled in the only cycle it stands
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // let n edges pass, settle after the last one
  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  // reset values at ports and readback, unmapped place reads zero
  task automatic t_reset();
    check(16'({o_c3a, o_c1a}), 16'h0003);
    check(16'(o_slp), 16'h0000);
    check(16'(o_off), 16'h0002);
    check(16'(o_on), 16'h0005);
    check(16'(o_comp_enable), 16'h0001);
    check(16'({o_irq, o_hard_shutdown}), 16'h0000);
    rd(CMS_ADDR_ACTIVE);
    check(d, 16'h0005);
    rd(CMS_ADDR_SLEEP);
    check(d, 16'h0000);
    rd(CMS_ADDR_SUPPLY);
    check(d, 16'h0025);
    idle(1);
    check(o_rdata, 16'h0000);
    rd(8'h55);
    check(d, 16'h0000);
  endtask
  // every mode bit set and cleared
  task automatic t_modes();
    wr(CMS_ADDR_ACTIVE, 16'h0004);
    check(16'({o_c3a, o_c1a}), 16'h0002);
    wr(CMS_ADDR_ACTIVE, 16'h0001);
    check(16'({o_c3a, o_c1a}), 16'h0001);
    wr(CMS_ADDR_SLEEP, 16'h0021);
    check(16'(o_slp), 16'h0009);
    wr(CMS_ADDR_SLEEP, 16'h000c);
    check(16'(o_slp), 16'h0006);
    rd(CMS_ADDR_SLEEP);
    check(d, 16'h000c);
  endtask
  // locked threshold write dropped, other bits taken, event flagged
  task automatic t_key();
    wr(CMS_ADDR_SUPPLY, 16'h4000);
    rd(CMS_ADDR_SUPPLY);
    check(d, 16'h4025);
    rd(CMS_ADDR_IRQ_STAT);
    check(d, 16'h0002);
    rd(CMS_ADDR_IRQ_STAT);
    check(d, 16'h0000);
    @(posedge i_mclk);
    i_key_unlocked <= 1'b1;
    wr(CMS_ADDR_SUPPLY, 16'h0070);
    check(16'(o_off), 16'h0007);
    check(16'(o_on), 16'h0000);
  endtask
  // state machine reset restores modes and action, keeps the rest
  task automatic t_smreset();
    wr(CMS_ADDR_ACTIVE, 16'h0000);
    wr(CMS_ADDR_SLEEP, 16'h002d);
    wr(CMS_ADDR_SUPPLY, 16'h5013);
    @(posedge i_mclk);
    i_sm_reset <= 1'b1;
    @(posedge i_mclk);
    i_sm_reset <= 1'b0;
    #1;
    check(16'({o_c3a, o_c1a}), 16'h0003);
    check(16'(o_slp), 16'h0000);
    rd(CMS_ADDR_SUPPLY);
    check(d, 16'h1013);
  endtask
  // supply drop with a given action and mask; hard-stop expected or not
  task automatic t_supply(input logic [15:0] cfg, input logic [15:0] msk, input logic stop);
    int n;
    logic seen_stop;
    seen_stop = 1'b0;
    wr(CMS_ADDR_SUPPLY, cfg);
    wr(CMS_ADDR_IRQ_MASK, msk);
    @(posedge i_mclk);
    i_supply_low <= 1'b1;
    for (n = 1; n <= 6; n++) begin
      @(posedge i_mclk);
      #1;
      if (o_hard_shutdown === 1'b1 && !seen_stop) begin
        seen_stop = 1'b1;
        check(16'(n), 16'h0003);
        check(16'(o_irq), msk & 16'h0001);
      end
    end
    check(16'(seen_stop), 16'(stop));
    check(16'(o_irq), msk & 16'h0001);
    @(posedge i_mclk);
    i_supply_low <= 1'b0;
    idle(4);
    rd(CMS_ADDR_IRQ_STAT);
    check(d, 16'h0001);
    check(16'(o_irq), 16'h0000);
  endtask
  // comparator in hibernate follows the use bit
  task automatic t_hib();
    wr(CMS_ADDR_SUPPLY, 16'h0025);
    @(posedge i_mclk);
    i_hibernate <= 1'b1;
    idle(2);
    check(16'(o_comp_enable), 16'h0000);
    @(posedge i_mclk);
    i_supply_low <= 1'b1;
    idle(6);
    rd(CMS_ADDR_IRQ_STAT);
    check(d, 16'h0000);
    @(posedge i_mclk);
    i_supply_low <= 1'b0;
    wr(CMS_ADDR_SUPPLY, 16'h1025);
    idle(2);
    check(16'(o_comp_enable), 16'h0001);
    // with the use bit set the comparator still reports in hibernate
    @(posedge i_mclk);
    i_supply_low <= 1'b1;
    idle(4);
    @(posedge i_mclk);
    i_supply_low <= 1'b0;
    i_hibernate <= 1'b0;
    rd(CMS_ADDR_IRQ_STAT);
    check(d, 16'h0001);
  endtask
  // locked write raises an enabled interrupt; mid-run reset restores defaults
  task automatic t_rerun();
    wr(CMS_ADDR_SUPPLY, 16'h0073);
    wr(CMS_ADDR_IRQ_MASK, 16'h0003);
    rd(CMS_ADDR_IRQ_MASK);
    check(d, 16'h0003);
    @(posedge i_mclk);
    i_key_unlocked <= 1'b0;
    wr(CMS_ADDR_SUPPLY, 16'h1000);
    check(16'(o_irq), 16'h0001);
    check(16'({o_off, o_on}), 16'h003b);
    @(posedge i_mclk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_srst <= 1'b0;
    #1;
    check(16'({o_off, o_on}), 16'h0015);
    check(16'({o_irq, o_hard_shutdown}), 16'h0000);
    rd(CMS_ADDR_SUPPLY);
    check(d, 16'h0025);
    rd(CMS_ADDR_IRQ_MASK);
    check(d, 16'h0000);
  endtask

  // ************************************************************
  // clock, watchdog, main sequence
  // ************************************************************
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  // verdict in one place
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // the run needs about 125 cycles; 5000 means a hang
  initial begin
    #20000;
    fails++;
    summarize();
  end
  initial begin
    fails = 0;
    total_checks = 0;
    i_srst = 1'b1;
    i_addr = '0;
    i_wdata = '0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_sm_reset = 1'b0;
    i_key_unlocked = 1'b0;
    i_hibernate = 1'b0;
    i_supply_low = 1'b0;
    repeat (2) @(posedge i_mclk);
    i_srst <= 1'b0;
    #1;
    t_reset();
    t_modes();
    t_key();
    t_smreset();
    t_supply(16'h4025, 16'h0001, 1'b1);
    t_supply(16'h0025, 16'h0000, 1'b0);
    t_hib();
    t_rerun();
    summarize();
  end
endmodule
